// ===== verilog/tcm_map.svh
// Offsets, field positions, reset values and timing values in nanoseconds of the main configuration registers
`ifndef TCM_MAP_SVH
`define TCM_MAP_SVH

// ==========================================================
// Register port
`define TCM_ADDR_W 5
`define TCM_DATA_W 8
`define TCM_ADDR_CHIP_CTRL 5'h00
`define TCM_ADDR_PROTO_SEL 5'h01
`define TCM_CHIP_CTRL_RST 8'h01
`define TCM_PROTO_SEL_RST 8'h02
`define TCM_UNMAPPED_RDATA 8'h00

// ==========================================================
// Chip power and carrier control fields
`define TCM_CC_STANDBY 7
`define TCM_CC_RAW 6
`define TCM_CC_CARRIER 5
`define TCM_CC_HALF_PWR 4
`define TCM_CC_AUX_IN 3
`define TCM_CC_AGC 2
`define TCM_CC_FORCE_RX 1
`define TCM_CC_SUPPLY 0

// ==========================================================
// Protocol select fields
`define TCM_PS_NO_CRC 7
`define TCM_PS_RAW_TYPE 6
`define TCM_PS_PEER 5
`define TCM_PS_BIT4 4
`define TCM_PS_BIT3 3
`define TCM_PS_BIT2 2
`define TCM_PS_BIT1 1
`define TCM_PS_BIT0 0

// ==========================================================
// Timing
`define TCM_WAKE_TIME_NS 100000
`define TCM_CLK_PERIOD_NS 100

`endif

// ===== verilog/tcm_pkg.sv
// Types shared by the main configuration register block
package tcm_pkg;

  // Power state, Gray along active -> standby -> waking
  typedef enum logic [1:0] {
    TCM_PWR_ACTIVE = 2'h0,
    TCM_PWR_STANDBY = 2'h1,
    TCM_PWR_WAKING = 2'h3
  } tcm_pwr_state_t;

  // Framing of host traffic
  typedef enum logic [1:0] {
    TCM_FRAME_AUTO = 2'h0,
    TCM_FRAME_RAW_AFE = 2'h1,
    TCM_FRAME_HOST = 2'h2
  } tcm_frame_mode_t;

  // Protocol family chosen by the protocol register
  typedef enum logic [2:0] {
    TCM_FAM_VICINITY = 3'h0,
    TCM_FAM_PROX_A = 3'h1,
    TCM_FAM_PROX_B = 3'h2,
    TCM_FAM_OTHER = 3'h3,
    TCM_FAM_PEER = 3'h4,
    TCM_FAM_CARD_EMU = 3'h5
  } tcm_family_t;

  // Analog front end steering
  typedef struct packed {
    logic tx_en;
    logic rx_en;
    logic tx_osc_en;
    logic half_power;
    logic aux_input;
    logic agc_en;
    logic supply_5v;
  } tcm_front_end_t;

  // Decoded protocol selection
  typedef struct packed {
    tcm_family_t family;
    logic crc_check;
    logic vic_one_of_256;
    logic vic_high_rate;
    logic vic_double_sub;
    logic [1:0] rate_code;
    logic peer_initiator;
    logic peer_active;
  } tcm_proto_t;

endpackage

// ===== verilog/tcm_pin_sync.sv
// Three-stage synchroniser for a pin level, output moves once stages two and three agree
`timescale 1ns/1ps
`include "tcm_map.svh"

module tcm_pin_sync #(
  parameter logic RESET_LEVEL = 1'b0
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // Pin and clean level
  input wire logic pin_i,
  output logic level_o
);

  logic s1_r;
  logic s2_r;
  logic s3_r;

  // Stage one feeds stage two only
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
    end else begin
      s1_r <= pin_i;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // Agreement of the later stages filters a metastable settle
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      level_o <= RESET_LEVEL;
    end else if (s2_r == s3_r) begin
      level_o <= s3_r;
    end
  end

endmodule

// ===== verilog/tcm_proto_decode.sv
// Decoder from the protocol register byte to protocol family and options
`timescale 1ns/1ps
`include "tcm_map.svh"

module tcm_proto_decode
  import tcm_pkg::*;
(
  // Raw register byte
  input wire logic [`TCM_DATA_W-1:0] code_i,
  // Decoded selection
  output tcm_proto_t proto_o
);

  always_comb begin
    proto_o = '0;
    proto_o.rate_code = code_i[`TCM_PS_BIT1:`TCM_PS_BIT0];
    proto_o.vic_one_of_256 = code_i[`TCM_PS_BIT0];
    proto_o.vic_high_rate = code_i[`TCM_PS_BIT1];
    proto_o.vic_double_sub = code_i[`TCM_PS_BIT2];
    if (code_i[`TCM_PS_PEER]) begin
      // Peer roles and card emulation
      proto_o.family = code_i[`TCM_PS_BIT2] ? TCM_FAM_CARD_EMU : TCM_FAM_PEER;
      proto_o.peer_initiator = code_i[`TCM_PS_BIT4];
      proto_o.peer_active = code_i[`TCM_PS_BIT3];
    end else if (code_i[`TCM_PS_BIT4]) begin
      // Upper codes are beyond this block's decoding
      proto_o.family = TCM_FAM_OTHER;
    end else if (!code_i[`TCM_PS_BIT3]) begin
      proto_o.family = TCM_FAM_VICINITY;
    end else if (!code_i[`TCM_PS_BIT2]) begin
      proto_o.family = TCM_FAM_PROX_A;
    end else begin
      proto_o.family = TCM_FAM_PROX_B;
    end
    // Checksum option only has meaning for type A and vicinity readers
    proto_o.crc_check = !code_i[`TCM_PS_NO_CRC] &&
                        (proto_o.family == TCM_FAM_VICINITY ||
                         proto_o.family == TCM_FAM_PROX_A);
  end

endmodule

// ===== verilog/tcm_main_config_regs.sv
// Main configuration registers: power, carrier, front end and protocol selection
`timescale 1ns/1ps
`include "tcm_map.svh"

module tcm_main_config_regs
  import tcm_pkg::*;
#(
  parameter int WAKE_CYCLES =
    (`TCM_WAKE_TIME_NS + `TCM_CLK_PERIOD_NS - 1) / `TCM_CLK_PERIOD_NS
) (
  // Clock and power-on reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // Enable pin, low presets the registers
  input wire logic en_i,
  // Host register port
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [`TCM_ADDR_W-1:0] reg_addr_i,
  input wire logic [`TCM_DATA_W-1:0] reg_wdata_i,
  output logic [`TCM_DATA_W-1:0] reg_rdata_o,
  output logic reg_rvalid_o,
  // Front end steering
  output tcm_front_end_t front_end_o,
  output tcm_frame_mode_t frame_mode_o,
  // Protocol selection
  output tcm_proto_t proto_o,
  output logic option_reload_o,
  output logic [`TCM_DATA_W-1:0] option_proto_o,
  // Power state
  output logic standby_o,
  output logic full_operation_o
);

  localparam int CNT_W = $clog2(WAKE_CYCLES + 1);

  // ==========================================================
  // Elaboration checks
  generate
    if (WAKE_CYCLES < 1) begin : g_bad_wake
      $error("WAKE_CYCLES must be at least one");
    end
    // Both registers are single bytes on the host port
    if (`TCM_DATA_W != 8) begin : g_bad_data_w
      $error("register port must be eight bits wide");
    end
    // Each offset must be reachable on the address bus
    if (`TCM_ADDR_W < 1 || `TCM_ADDR_PROTO_SEL >= (1 << `TCM_ADDR_W)) begin : g_bad_addr_w
      $error("register offset outside the address range");
    end
    // Two registers on one offset would make the read mux ambiguous
    if (`TCM_ADDR_CHIP_CTRL == `TCM_ADDR_PROTO_SEL) begin : g_bad_map
      $error("register offsets overlap");
    end
    // Field positions must lie inside the byte
    if (`TCM_CC_STANDBY >= `TCM_DATA_W || `TCM_PS_NO_CRC >= `TCM_DATA_W) begin : g_bad_field
      $error("field position outside the register");
    end
  endgenerate

  // ==========================================================
  // Declarations
  logic en_level;
  logic preset;
  logic wr_chip;
  logic wr_proto;
  logic rd_hit_chip;
  logic rd_hit_proto;
  logic [`TCM_DATA_W-1:0] chip_ctrl_r;
  logic [`TCM_DATA_W-1:0] proto_sel_r;
  tcm_proto_t proto_dec;
  tcm_pwr_state_t pwr_state_r;
  tcm_pwr_state_t pwr_state_nxt;
  logic [CNT_W-1:0] wake_cnt_r;
  logic wake_done;
  logic active;
  logic carrier;
  logic force_rx;

  // ==========================================================
  // Enable pin
  // Pin is asynchronous to the device clock, so it is filtered first
  tcm_pin_sync #(
    .RESET_LEVEL(1'b0)
  ) u_en_sync (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .pin_i(en_i),
    .level_o(en_level)
  );

  // Enable low holds both host registers and the option outputs at their presets
  assign preset = !en_level;

  // ==========================================================
  // Address decode
  // Only the two main registers live here; other offsets belong elsewhere
  assign wr_chip = reg_wr_i && (reg_addr_i == `TCM_ADDR_CHIP_CTRL);
  assign wr_proto = reg_wr_i && (reg_addr_i == `TCM_ADDR_PROTO_SEL);
  assign rd_hit_chip = reg_addr_i == `TCM_ADDR_CHIP_CTRL;
  assign rd_hit_proto = reg_addr_i == `TCM_ADDR_PROTO_SEL;

  // ==========================================================
  // Chip power and carrier control register
  // Writes during preset are dropped; the device is held off by enable
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      chip_ctrl_r <= `TCM_CHIP_CTRL_RST;
    end else if (preset) begin
      chip_ctrl_r <= `TCM_CHIP_CTRL_RST;
    end else if (wr_chip) begin
      chip_ctrl_r <= reg_wdata_i;
    end
  end

  // ==========================================================
  // Protocol select register
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      proto_sel_r <= `TCM_PROTO_SEL_RST;
    end else if (preset) begin
      proto_sel_r <= `TCM_PROTO_SEL_RST;
    end else if (wr_proto) begin
      proto_sel_r <= reg_wdata_i;
    end
  end

  // ==========================================================
  // Read path
  // Data answers one cycle after the strobe; unmapped offsets read zero
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      reg_rvalid_o <= 1'b0;
    end else begin
      reg_rvalid_o <= reg_rd_i;
    end
  end

  // Data holds between reads, so a host that samples late still sees it
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      reg_rdata_o <= `TCM_UNMAPPED_RDATA;
    end else if (reg_rd_i) begin
      if (rd_hit_chip) begin
        reg_rdata_o <= chip_ctrl_r;
      end else if (rd_hit_proto) begin
        reg_rdata_o <= proto_sel_r;
      end else begin
        reg_rdata_o <= `TCM_UNMAPPED_RDATA;
      end
    end
  end

  // ==========================================================
  // Power state machine
  // Standby keeps the clock running, so the wake wait is counted here
  always_comb begin
    pwr_state_nxt = pwr_state_r;
    unique case (pwr_state_r)
      TCM_PWR_ACTIVE: begin
        if (chip_ctrl_r[`TCM_CC_STANDBY]) begin
          pwr_state_nxt = TCM_PWR_STANDBY;
        end
      end
      TCM_PWR_STANDBY: begin
        if (!chip_ctrl_r[`TCM_CC_STANDBY]) begin
          pwr_state_nxt = TCM_PWR_WAKING;
        end
      end
      TCM_PWR_WAKING: begin
        if (chip_ctrl_r[`TCM_CC_STANDBY]) begin
          pwr_state_nxt = TCM_PWR_STANDBY;
        end else if (wake_done) begin
          pwr_state_nxt = TCM_PWR_ACTIVE;
        end
      end
      default: begin
        pwr_state_nxt = TCM_PWR_STANDBY;
      end
    endcase
  end

  // State register
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pwr_state_r <= TCM_PWR_ACTIVE;
    end else begin
      pwr_state_r <= pwr_state_nxt;
    end
  end

  // ==========================================================
  // Wake timer
  // Restarts on every entry to waking, so a short standby still waits in full
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wake_cnt_r <= '0;
    end else if (pwr_state_r != TCM_PWR_WAKING) begin
      wake_cnt_r <= '0;
    end else if (!wake_done) begin
      wake_cnt_r <= wake_cnt_r + CNT_W'(1);
    end
  end

  assign wake_done = wake_cnt_r >= CNT_W'(WAKE_CYCLES - 1);
  assign active = pwr_state_r == TCM_PWR_ACTIVE;

  // ==========================================================
  // Front end steering
  assign carrier = chip_ctrl_r[`TCM_CC_CARRIER];
  assign force_rx = chip_ctrl_r[`TCM_CC_FORCE_RX];

  // Registered so the analog controls never see decode glitches
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      front_end_o <= '0;
    end else begin
      front_end_o.tx_en <= active && carrier;
      front_end_o.rx_en <= active && (carrier || force_rx);
      front_end_o.tx_osc_en <= active && (carrier || force_rx);
      front_end_o.half_power <= chip_ctrl_r[`TCM_CC_HALF_PWR];
      front_end_o.aux_input <= chip_ctrl_r[`TCM_CC_AUX_IN];
      front_end_o.agc_en <= active && chip_ctrl_r[`TCM_CC_AGC];
      front_end_o.supply_5v <= chip_ctrl_r[`TCM_CC_SUPPLY];
    end
  end

  // ==========================================================
  // Framing mode
  // The raw variant follows the protocol register every cycle while
  // raw access is on; a later protocol write switches it two cycles after its strobe
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      frame_mode_o <= TCM_FRAME_AUTO;
    end else if (!chip_ctrl_r[`TCM_CC_RAW]) begin
      frame_mode_o <= TCM_FRAME_AUTO;
    end else if (proto_sel_r[`TCM_PS_RAW_TYPE]) begin
      frame_mode_o <= TCM_FRAME_HOST;
    end else begin
      frame_mode_o <= TCM_FRAME_RAW_AFE;
    end
  end

  // ==========================================================
  // Protocol decode
  tcm_proto_decode u_decode (
    .code_i(proto_sel_r),
    .proto_o(proto_dec)
  );

  // Decoded selection held in flops
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      proto_o <= '0;
    end else begin
      proto_o <= proto_dec;
    end
  end

  // ==========================================================
  // Option register reload
  // Reload pulses one cycle after each protocol write and stays up during
  // preset; even rewriting the same code discards custom option settings
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      option_reload_o <= 1'b1;
    end else if (preset) begin
      option_reload_o <= 1'b1;
    end else begin
      option_reload_o <= wr_proto;
    end
  end

  // Code the option defaults belong to; kept apart so it stands between reloads
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      option_proto_o <= `TCM_PROTO_SEL_RST;
    end else if (preset) begin
      option_proto_o <= `TCM_PROTO_SEL_RST;
    end else if (wr_proto) begin
      option_proto_o <= reg_wdata_i;
    end
  end

  // ==========================================================
  // Power status
  // Taken from the next state so the flag lines up with the state register
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      standby_o <= 1'b0;
    end else begin
      standby_o <= pwr_state_nxt == TCM_PWR_STANDBY;
    end
  end

  // Full operation also needs enable, since a preset holds the device off
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      full_operation_o <= 1'b0;
    end else begin
      full_operation_o <= pwr_state_nxt == TCM_PWR_ACTIVE && en_level;
    end
  end

endmodule

// ===== testbench/tcm_main_config_regs_chk.sv
// Checker for the main configuration register block
`timescale 1ns/1ps
`include "tcm_map.svh"

module tcm_main_config_regs_chk
  import tcm_pkg::*;
#(
  parameter int WAKE_CYCLES = 1000
) (
  // Clock, reset and enable
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic en_i,
  // Register port
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [`TCM_ADDR_W-1:0] reg_addr_i,
  input wire logic [`TCM_DATA_W-1:0] reg_wdata_i,
  input wire logic [`TCM_DATA_W-1:0] reg_rdata_o,
  input wire logic reg_rvalid_o,
  // Watched outputs
  input wire tcm_front_end_t front_end_o,
  input wire tcm_proto_t proto_o,
  input wire logic option_reload_o,
  input wire logic [`TCM_DATA_W-1:0] option_proto_o,
  input wire logic standby_o,
  input wire logic full_operation_o
);
  // ==========
  // Helper logic
  logic [2:0] en_cnt_r;
  logic ok_w;
  int wake_seen_r;
  // Writes count as taken only once enable is past the synchroniser
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      en_cnt_r <= 3'h0;
    end else if (!en_i) begin
      en_cnt_r <= 3'h0;
    end else if (en_cnt_r != 3'h7) begin
      en_cnt_r <= en_cnt_r + 3'h1;
    end
  end
  assign ok_w = (en_cnt_r == 3'h7) && en_i;

  // Cycles since standby was last shown, saturating at the wake time
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wake_seen_r <= WAKE_CYCLES;
    end else if (standby_o) begin
      wake_seen_r <= 0;
    end else if (wake_seen_r < WAKE_CYCLES) begin
      wake_seen_r <= wake_seen_r + 1;
    end
  end

  // ==========
  // Sequences and assertions
  default clocking dc @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  sequence wr0_s; ok_w && reg_wr_i && reg_addr_i == `TCM_ADDR_CHIP_CTRL; endsequence
  sequence wr1_s; ok_w && reg_wr_i && reg_addr_i == `TCM_ADDR_PROTO_SEL; endsequence

  read_answer_a: assert property (reg_rvalid_o == $past(reg_rd_i))
    else $error("read answer not one cycle after strobe");
  unmapped_read_a: assert property (reg_rd_i && reg_addr_i > `TCM_ADDR_PROTO_SEL |=>
    reg_rdata_o == 8'h00) else $error("unmapped read not zero");
  option_reload_a: assert property (wr1_s |=> option_reload_o &&
    option_proto_o == $past(reg_wdata_i)) else $error("option reload missing");
  type_a_a: assert property (wr1_s ##0 reg_wdata_i[5:2] == 4'h2 ##1 !reg_wr_i |=>
    proto_o.family == TCM_FAM_PROX_A && proto_o.rate_code == $past(reg_wdata_i[1:0], 2))
    else $error("type A decode wrong");
  type_b_a: assert property (wr1_s ##0 reg_wdata_i[5:2] == 4'h3 ##1 !reg_wr_i |=>
    proto_o.family == TCM_FAM_PROX_B && proto_o.rate_code == $past(reg_wdata_i[1:0], 2))
    else $error("type B decode wrong");
  enter_standby_a: assert property (wr0_s ##0 reg_wdata_i[7] ##1 !reg_wr_i |=> standby_o)
    else $error("standby not entered");
  standby_gate_a: assert property (standby_o [*2] |->
    !front_end_o.tx_en && !front_end_o.rx_en) else $error("carrier on in standby");
  front_levels_a: assert property (wr0_s ##1 !reg_wr_i |=>
    front_end_o.half_power == $past(reg_wdata_i[4], 2) &&
    front_end_o.aux_input == $past(reg_wdata_i[3], 2) &&
    front_end_o.supply_5v == $past(reg_wdata_i[0], 2)) else $error("front end levels wrong");
  full_op_a: assert property (full_operation_o |-> !standby_o)
    else $error("full operation while in standby");
  wake_time_a: assert property ($rose(full_operation_o) |-> wake_seen_r >= WAKE_CYCLES)
    else $error("full operation before the wake time");
  enable_preset_a: assert property (!en_i [*6] |-> option_reload_o &&
    option_proto_o == 8'h02) else $error("preset not held with enable low");
endmodule

bind tcm_main_config_regs tcm_main_config_regs_chk #(.WAKE_CYCLES(WAKE_CYCLES)) chk_i (
  .clk_i(clk_i), .nrst_i(nrst_i), .en_i(en_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
  .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
  .reg_rvalid_o(reg_rvalid_o), .front_end_o(front_end_o), .proto_o(proto_o),
  .option_reload_o(option_reload_o), .option_proto_o(option_proto_o),
  .standby_o(standby_o), .full_operation_o(full_operation_o));

// ===== testbench/tcm_host_model.sv
// Host model that drives the register port of the configuration block
`timescale 1ns/1ps
`include "tcm_map.svh"

module tcm_host_model (
  // Clock
  input wire logic clk_i,
  // Register port
  output logic reg_wr_o,
  output logic reg_rd_o,
  output logic [`TCM_ADDR_W-1:0] reg_addr_o,
  output logic [`TCM_DATA_W-1:0] reg_wdata_o,
  input wire logic [`TCM_DATA_W-1:0] reg_rdata_i,
  input wire logic reg_rvalid_i
);
  // ==========
  // Idle levels
  initial begin
    reg_wr_o = 1'b0;
    reg_rd_o = 1'b0;
    reg_addr_o = 5'h1f;
    reg_wdata_o = 8'h55;
  end

  // ==========
  // Bus cycles, inverted address when idle and inverted data after a write, so stale values cannot pass
  task automatic wr(input logic [`TCM_ADDR_W-1:0] a, input logic [`TCM_DATA_W-1:0] d);
    @(negedge clk_i);
    reg_addr_o = a;
    reg_wdata_o = d;
    reg_wr_o = 1'b1;
    @(negedge clk_i);
    reg_wr_o = 1'b0;
    reg_addr_o = ~a;
    reg_wdata_o = ~d;
  endtask

  task automatic rd(input logic [`TCM_ADDR_W-1:0] a, output logic [`TCM_DATA_W-1:0] d);
    @(negedge clk_i);
    reg_addr_o = a;
    reg_rd_o = 1'b1;
    @(negedge clk_i);
    reg_rd_o = 1'b0;
    reg_addr_o = ~a;
    d = reg_rvalid_i ? reg_rdata_i : 'x;
  endtask
endmodule

// ===== testbench/tb.sv
// Self-checking bench for the main configuration register block
`timescale 1ns/1ps
`include "tcm_map.svh"

module tb;
  import tcm_pkg::*;
  localparam int WAKE = 5;
  logic clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic en_i = 1'b0;
  logic reg_wr_i, reg_rd_i, reg_rvalid_o, option_reload_o, standby_o, full_operation_o;
  logic [`TCM_ADDR_W-1:0] reg_addr_i;
  logic [`TCM_DATA_W-1:0] reg_wdata_i, reg_rdata_o, option_proto_o, rd_v, c;
  tcm_front_end_t front_end_o;
  tcm_frame_mode_t frame_mode_o;
  tcm_proto_t proto_o;
  tcm_family_t fam;
  int fails = 0;
  int checked = 0;
  int cyc = 0;
  int n;

  // ==========
  // Clock, timeout and instances
  always #50 clk_i = ~clk_i;
  // A hang ends the run as a failure
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fails = fails + 1;
      stop_test();
    end
  end
  tcm_main_config_regs #(.WAKE_CYCLES(WAKE)) tcm_main_config_regs_i (.clk_i(clk_i),
    .nrst_i(nrst_i), .en_i(en_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
    .reg_rvalid_o(reg_rvalid_o), .front_end_o(front_end_o), .frame_mode_o(frame_mode_o),
    .proto_o(proto_o), .option_reload_o(option_reload_o), .option_proto_o(option_proto_o),
    .standby_o(standby_o), .full_operation_o(full_operation_o));
  tcm_host_model tcm_host_model_i (.clk_i(clk_i), .reg_wr_o(reg_wr_i), .reg_rd_o(reg_rd_i),
    .reg_addr_o(reg_addr_i), .reg_wdata_o(reg_wdata_i), .reg_rdata_i(reg_rdata_o),
    .reg_rvalid_i(reg_rvalid_o));

  // ==========
  // Shared tasks
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checked = checked + 1;
    if (seen !== exp) begin
      fails = fails + 1;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    tcm_host_model_i.wr(a, d);
  endtask
  task automatic rdc(input string s, input logic [4:0] a, input logic [7:0] e);
    tcm_host_model_i.rd(a, rd_v);
    chk(s, rd_v, e);
  endtask
  task automatic stop_test();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // Expected family from the protocol code
  function automatic tcm_family_t fam_of(input logic [7:0] k);
    if (k[5]) return k[2] ? TCM_FAM_CARD_EMU : TCM_FAM_PEER;
    if (k[4]) return TCM_FAM_OTHER;
    if (!k[3]) return TCM_FAM_VICINITY;
    return k[2] ? TCM_FAM_PROX_B : TCM_FAM_PROX_A;
  endfunction

  // ==========
  // Main sequence
  initial begin
    repeat (12) @(posedge clk_i);
    @(negedge clk_i);
    nrst_i = 1'b1;
    en_i = 1'b1;
    repeat (8) @(negedge clk_i);
    rdc("chip_rst", `TCM_ADDR_CHIP_CTRL, 8'h01);
    rdc("proto_rst", `TCM_ADDR_PROTO_SEL, 8'h02);
    // Every reader code, upper ones too, with and without checksum, then peer codes
    for (n = 0; n < 72; n++) begin
      c = (n < 64) ? {n[5], 2'h0, n[4:0]} : {3'h1, n[2:0], 2'h1};
      wr(`TCM_ADDR_PROTO_SEL, c);
      chk("reload", {option_reload_o, option_proto_o}, {1'b1, c});
      @(negedge clk_i);
      fam = fam_of(c);
      chk("reload_end", option_reload_o, 1'b0);
      chk("family", proto_o.family, fam);
      if (fam == TCM_FAM_VICINITY) chk("vic", {proto_o.vic_double_sub, proto_o.vic_high_rate,
        proto_o.vic_one_of_256}, c[2:0]);
      if (fam inside {TCM_FAM_PROX_A, TCM_FAM_PROX_B}) begin
        chk("rate", proto_o.rate_code, c[1:0]);
      end
      if (c[5]) chk("peer", {proto_o.peer_initiator, proto_o.peer_active}, c[4:3]);
      chk("crc", proto_o.crc_check, !c[7] && fam inside {TCM_FAM_VICINITY, TCM_FAM_PROX_A});
    end
    rdc("proto_rb", `TCM_ADDR_PROTO_SEL, c);
    // Raw type is programmed before the raw access bit
    wr(`TCM_ADDR_PROTO_SEL, 8'h42);
    wr(`TCM_ADDR_CHIP_CTRL, 8'h41);
    @(negedge clk_i);
    chk("frame_host", frame_mode_o, TCM_FRAME_HOST);
    wr(`TCM_ADDR_PROTO_SEL, 8'h02);
    @(negedge clk_i);
    chk("frame_raw", frame_mode_o, TCM_FRAME_RAW_AFE);
    wr(`TCM_ADDR_CHIP_CTRL, 8'h01);
    @(negedge clk_i);
    chk("frame_auto", frame_mode_o, TCM_FRAME_AUTO);
    // Front end steering: carrier with all options but forced receive, forced receive alone, all off
    for (n = 0; n < 3; n++) begin
      c = (n == 0) ? 8'h3d : (n == 1) ? 8'h02 : 8'h00;
      wr(`TCM_ADDR_CHIP_CTRL, c);
      @(negedge clk_i);
      chk("front_end", front_end_o & (n == 0 ? 7'h6f : 7'h7f),
        n == 0 ? 7'h6f : n == 1 ? 7'h30 : 7'h00);
    end
    wr(5'h03, 8'h80);
    rdc("unmapped", 5'h03, 8'h00);
    rdc("chip_keep", `TCM_ADDR_CHIP_CTRL, 8'h00);
    // Standby and the wake-up delay
    wr(`TCM_ADDR_CHIP_CTRL, 8'ha1);
    repeat (2) @(negedge clk_i);
    chk("standby", {standby_o, full_operation_o, front_end_o.tx_en}, 3'h4);
    wr(`TCM_ADDR_CHIP_CTRL, 8'h21);
    n = 0;
    while (full_operation_o !== 1'b1 && n < 100) begin
      @(negedge clk_i);
      n++;
    end
    chk("wake", n >= WAKE - 1 && n <= WAKE + 3, 1'b1);
    @(negedge clk_i);
    chk("tx_back", front_end_o.tx_en, 1'b1);
    // Enable low presets and refuses writes
    wr(`TCM_ADDR_PROTO_SEL, 8'h0d);
    en_i = 1'b0;
    repeat (8) @(negedge clk_i);
    wr(`TCM_ADDR_PROTO_SEL, 8'h0c);
    en_i = 1'b1;
    repeat (8) @(negedge clk_i);
    rdc("preset_chip", `TCM_ADDR_CHIP_CTRL, 8'h01);
    rdc("preset_proto", `TCM_ADDR_PROTO_SEL, 8'h02);
    // Second power-on reset in mid-run
    wr(`TCM_ADDR_PROTO_SEL, 8'h0d);
    nrst_i = 1'b0;
    repeat (2) @(negedge clk_i);
    nrst_i = 1'b1;
    repeat (8) @(negedge clk_i);
    rdc("por_proto", `TCM_ADDR_PROTO_SEL, 8'h02);
    stop_test();
  end
endmodule
